//--- src/mbox_pkg.sv
// Package: mailbox register map, field positions and shared types
package mbox_pkg;

  // ************************************************************
  // Address map
  // ************************************************************
  localparam logic [11:0] RAM_FIRST       = 12'h004;
  localparam logic [11:0] RAM_LAST        = 12'h41F;
  localparam logic [11:0] TARGET_DOORBELL = 12'h500;
  localparam logic [11:0] PROC_DOORBELL   = 12'h501;
  localparam logic [11:0] H2P_LENGTH      = 12'h502;
  localparam logic [11:0] P2H_LENGTH      = 12'h503;
  localparam logic [11:0] XFER_ATTR       = 12'h504;
  localparam logic [11:0] CMD_STATUS      = 12'h505;
  localparam logic [11:0] ERR_DET_CTRL    = 12'h506;
  localparam logic [11:0] ERR_STATUS      = 12'h507;
  localparam logic [11:0] REGBUS_CMD0     = 12'h600;
  localparam logic [11:0] REGBUS_CMD3     = 12'h603;
  localparam logic [11:0] REGBUS_DATA0    = 12'h604;
  localparam logic [11:0] REGBUS_DATA7    = 12'h60B;
  localparam logic [11:0] REGBUS_CTRL     = 12'h60C;

  // ************************************************************
  // Doorbell bit positions
  // ************************************************************
  localparam int DB_DIAG      = 7;
  localparam int DB_ABORT     = 6;
  localparam int DB_RESET     = 5;
  localparam int DB_RD_SENT   = 4;
  localparam int DB_WR_READY  = 3;
  localparam int DB_SOFT_RST  = 2;
  localparam int DB_IDENTIFY  = 1;
  localparam int DB_PACKET    = 0;
  localparam int PD_ABORTED   = 7;
  localparam int PD_RD_READY  = 5;
  localparam int PD_PKT_ACK   = 0;
  localparam int ATTR_DIR     = 0;
  localparam int ATTR_LAST    = 1;
  localparam int EDC_ENABLE   = 0;

  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [7:0] EDC_RESET    = 8'h01;
  localparam logic [7:0] DOORBELL_MSK = 8'hFF;
  localparam logic [7:0] PROC_DB_MSK  = 8'hF9;
  localparam logic [7:0] ATTR_MSK     = 8'h03;
  localparam logic [7:0] EDC_MSK      = 8'h07;
  localparam logic [7:0] ERRST_MSK    = 8'hC3;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic packet;
    logic identify;
    logic soft_reset;
    logic write_ready;
    logic read_sent;
    logic dev_reset;
    logic abort;
    logic diag;
  } target_event_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        crc_err;
  } slave_req_t;

  typedef struct packed {
    logic [9:0]  addr;
    logic [7:0]  data;
    logic        we;
  } ram_port_t;

  typedef enum logic [1:0] {
    RB_IDLE = 2'b00,
    RB_BUSY = 2'b01,
    RB_DONE = 2'b10
  } regbus_state_t;

endpackage

//--- src/mbox_event_sync.sv
// Event crossing from the link clock into the core clock by toggle
`timescale 1ns/1ps
module mbox_event_sync
  import mbox_pkg::*;
(
  input  wire logic link_clk,
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic link_pulse,
  output logic      core_pulse
);

  logic toggle;
  logic sync_a;
  logic sync_b;
  logic sync_c;

  // Link clock may stop between frames; the toggle level survives that
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      toggle <= 1'b0;
    end else if (link_pulse) begin
      toggle <= ~toggle;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else if (ce) begin
      sync_a <= toggle;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign core_pulse = ce & (sync_b ^ sync_c);

endmodule

//--- src/stp_enclosure_mailbox.sv
// Mailbox between the STP target link and the enclosure processor slave space
//
// Functional notes
// - Mailbox space only reachable through management port
// - Packet command: CDB in RAM, doorbell
// - Diagnostics sets bit 7, write one clears
// - Abort bit 6 on listed link faults
// - Reconnect or open failure also aborts
// - Link or device reset sets reset doorbell
// - Read data sent acknowledges read ready
// - Host write data ready sets doorbell
// - Transfer length loaded from byte count
// - CRC error sets processor aborted bit
// - Direction bit: zero out, one in
`timescale 1ns/1ps
module stp_enclosure_mailbox
  import mbox_pkg::*;
#(
  parameter int RAM_WORDS = 1052
)(
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  input  wire logic          link_clk,
  input  wire slave_req_t    mgmt_req,
  output logic [7:0]         mgmt_rdata,
  output logic               proc_irq,
  input  wire target_event_t link_event,
  input  wire logic [7:0]    link_byte_count,
  input  wire ram_port_t     link_ram,
  output logic [7:0]         link_ram_rdata,
  output logic               proc_read_ready,
  output logic               proc_packet_ack,
  output logic               proc_write_ack,
  output logic               proc_status_ready,
  output logic               proc_aborted,
  output logic [7:0]         proc_length,
  output logic [7:0]         attributes,
  output logic [7:0]         command_status,
  output logic [31:0]        regbus_command,
  output logic [63:0]        regbus_wdata,
  output logic               regbus_req,
  input  wire logic          regbus_done,
  input  wire logic [63:0]   regbus_rdata
);

  // ************************************************************
  // Link events crossed into the core domain
  // ************************************************************
  logic [7:0] event_core;
  logic [7:0] link_event_bits;
  logic [7:0] byte_count_link;
  logic [7:0] byte_count_sync;
  logic [7:0] byte_count_core;
  // Struct fields run opposite to the doorbell bits, so reverse them here
  assign link_event_bits = {<<{link_event}};
  for (genvar i = 0; i < 8; i++) begin : g_evt
    mbox_event_sync u_sync (
      .link_clk   (link_clk),
      .clk        (clk),
      .rst_b      (rst_b),
      .ce         (ce),
      .link_pulse (link_event_bits[i]),
      .core_pulse (event_core[i])
    );
  end
  // Byte count is captured with the packet event and is stable once it crosses
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      byte_count_link <= RESET_BYTE;
    end else if (link_event.packet) begin
      byte_count_link <= link_byte_count;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      byte_count_sync <= RESET_BYTE;
      byte_count_core <= RESET_BYTE;
    end else if (ce) begin
      byte_count_sync <= byte_count_link;
      byte_count_core <= byte_count_sync;
    end
  end

  // ************************************************************
  // Slave access decode, only from the management port
  // ************************************************************
  logic wr;
  logic rd;
  logic in_ram;
  logic crc_enable;
  logic [10:0] ram_index;
  assign wr = ce & mgmt_req.wr;
  assign rd = ce & mgmt_req.rd;
  assign in_ram = (mgmt_req.addr >= RAM_FIRST) && (mgmt_req.addr <= RAM_LAST);
  assign ram_index = 11'(mgmt_req.addr - RAM_FIRST);

  // ************************************************************
  // Data FIS RAM, written only on the core clock
  // ************************************************************
  logic [7:0] fis_ram [RAM_WORDS];
  logic [7:0] ram_rdata;
  logic [9:0] link_wr_addr;
  logic [7:0] link_wr_data;
  logic       link_wr_core;
  // Link writes are held here and replayed on the core clock; at most one per two link clocks
  always_ff @(posedge link_clk) begin
    if (link_ram.we) begin
      link_wr_addr <= link_ram.addr;
      link_wr_data <= link_ram.data;
    end
    link_ram_rdata <= fis_ram[link_ram.addr];
  end
  mbox_event_sync u_ram_sync (
    .link_clk (link_clk), .clk (clk), .rst_b (rst_b), .ce (ce),
    .link_pulse (link_ram.we), .core_pulse (link_wr_core)
  );
  // Link and processor take turns by doorbell handshake; the link write wins a clash
  always_ff @(posedge clk) begin
    if (link_wr_core) begin
      fis_ram[{1'b0, link_wr_addr}] <= link_wr_data;
    end else if (wr && in_ram) begin
      fis_ram[ram_index] <= mgmt_req.wdata;
    end
  end
  assign ram_rdata = fis_ram[ram_index];

  // ************************************************************
  // Target-to-processor doorbell
  // ************************************************************
  logic [7:0] target_doorbell;
  logic [7:0] db_clear;
  assign db_clear = (wr && mgmt_req.addr == TARGET_DOORBELL) ? mgmt_req.wdata : RESET_BYTE;
  // Set beats clear so no event is lost in the clearing cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      target_doorbell <= RESET_BYTE;
    end else if (ce) begin
      target_doorbell <= (target_doorbell & ~db_clear) | event_core;
    end
  end
  assign proc_irq = |target_doorbell;

  // ************************************************************
  // Processor doorbell and aborted flag
  // ************************************************************
  logic [7:0] proc_doorbell;
  logic       crc_abort;
  assign crc_abort = ce & mgmt_req.crc_err & crc_enable;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      proc_doorbell <= RESET_BYTE;
    end else if (ce) begin
      if (wr && mgmt_req.addr == PROC_DOORBELL) begin
        proc_doorbell <= mgmt_req.wdata & PROC_DB_MSK;
      end
      if (crc_abort) begin
        proc_doorbell[PD_ABORTED] <= 1'b1;
      end
    end
  end
  assign proc_read_ready   = proc_doorbell[PD_RD_READY];
  assign proc_packet_ack   = proc_doorbell[PD_PKT_ACK];
  assign proc_write_ack    = proc_doorbell[4];
  assign proc_status_ready = proc_doorbell[6];
  assign proc_aborted      = proc_doorbell[PD_ABORTED];

  // ************************************************************
  // Lengths, attributes, status
  // ************************************************************
  logic [7:0] host_length;
  logic       packet_in;
  assign packet_in = event_core[DB_PACKET];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_length <= RESET_BYTE;
    end else if (packet_in) begin
      host_length <= byte_count_core;
    end else if (wr && mgmt_req.addr == H2P_LENGTH) begin
      host_length <= mgmt_req.wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      proc_length    <= RESET_BYTE;
      attributes     <= RESET_BYTE;
      command_status <= RESET_BYTE;
    end else if (wr) begin
      if (mgmt_req.addr == P2H_LENGTH) begin
        proc_length <= mgmt_req.wdata;
      end
      if (mgmt_req.addr == XFER_ATTR) begin
        attributes <= mgmt_req.wdata & ATTR_MSK;
      end
      if (mgmt_req.addr == CMD_STATUS) begin
        command_status <= mgmt_req.wdata;
      end
    end
  end

  // ************************************************************
  // Error detection control and status
  // ************************************************************
  logic [7:0] err_ctrl;
  logic [7:0] err_status;
  assign crc_enable = err_ctrl[EDC_ENABLE];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_ctrl <= EDC_RESET;
    end else if (ce) begin
      if (wr && mgmt_req.addr == ERR_DET_CTRL) begin
        err_ctrl[EDC_ENABLE] <= mgmt_req.wdata[EDC_ENABLE];
        err_ctrl[2:1] <= err_ctrl[2:1] & ~mgmt_req.wdata[2:1];
      end
      if (crc_abort) begin
        err_ctrl[1] <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_status <= RESET_BYTE;
    end else if (ce) begin
      if (wr && mgmt_req.addr == ERR_STATUS) begin
        err_status[1:0] <= err_status[1:0] & ~mgmt_req.wdata[1:0];
      end
      if (crc_abort) begin
        err_status[7] <= mgmt_req.rd;
      end
    end
  end

  // ************************************************************
  // Register bus command window
  // ************************************************************
  logic [7:0]    regbus_ctrl;
  regbus_state_t rb_state;
  logic [63:0]   regbus_data;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regbus_command <= '0;
    end else if (wr && mgmt_req.addr >= REGBUS_CMD0 && mgmt_req.addr <= REGBUS_CMD3) begin
      regbus_command[8*mgmt_req.addr[1:0] +: 8] <= mgmt_req.wdata;
    end
  end
  // Returned read data overwrites the data bytes when the operation ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regbus_data <= '0;
    end else if (ce) begin
      if (rb_state == RB_BUSY && regbus_done) begin
        regbus_data <= regbus_rdata;
      end else if (wr && mgmt_req.addr >= REGBUS_DATA0 && mgmt_req.addr <= REGBUS_DATA7) begin
        regbus_data[8*(3'(mgmt_req.addr - REGBUS_DATA0)) +: 8] <= mgmt_req.wdata;
      end
    end
  end
  assign regbus_wdata = regbus_data;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regbus_ctrl <= RESET_BYTE;
    end else if (wr && mgmt_req.addr == REGBUS_CTRL) begin
      regbus_ctrl <= {7'h00, mgmt_req.wdata[0]};
    end
  end
  // Request bit must be cleared by software before the next operation
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rb_state <= RB_IDLE;
    end else if (ce) begin
      case (rb_state)
        RB_IDLE: if (regbus_ctrl[0]) rb_state <= RB_BUSY;
        RB_BUSY: if (regbus_done) rb_state <= RB_DONE;
        RB_DONE: if (!regbus_ctrl[0]) rb_state <= RB_IDLE;
        default: rb_state <= RB_IDLE;
      endcase
    end
  end
  assign regbus_req = (rb_state == RB_BUSY);

  // ************************************************************
  // Read-back mux
  // ************************************************************
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = RESET_BYTE;
    if (in_ram) begin
      next_rdata = ram_rdata;
    end else begin
      case (mgmt_req.addr)
        TARGET_DOORBELL: next_rdata = target_doorbell;
        PROC_DOORBELL:   next_rdata = proc_doorbell;
        H2P_LENGTH:      next_rdata = host_length;
        P2H_LENGTH:      next_rdata = proc_length;
        XFER_ATTR:       next_rdata = attributes;
        CMD_STATUS:      next_rdata = command_status;
        ERR_DET_CTRL:    next_rdata = err_ctrl & EDC_MSK;
        ERR_STATUS:      next_rdata = err_status & ERRST_MSK;
        REGBUS_CTRL:     next_rdata = regbus_ctrl;
        default: begin
          if (mgmt_req.addr >= REGBUS_CMD0 && mgmt_req.addr <= REGBUS_CMD3) begin
            next_rdata = regbus_command[8*mgmt_req.addr[1:0] +: 8];
          end else if (mgmt_req.addr >= REGBUS_DATA0 && mgmt_req.addr <= REGBUS_DATA7) begin
            next_rdata = regbus_data[8*(3'(mgmt_req.addr - REGBUS_DATA0)) +: 8];
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_rdata <= RESET_BYTE;
    end else if (rd) begin
      mgmt_rdata <= next_rdata;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_diag_sets_bit: assert property (@(posedge clk) disable iff (!rst_b)
    event_core[DB_DIAG] |=> target_doorbell[DB_DIAG])
    else $error("diagnostic doorbell not set");
  a_abort_sets_bit: assert property (@(posedge clk) disable iff (!rst_b)
    event_core[DB_ABORT] |=> target_doorbell[DB_ABORT])
    else $error("abort doorbell not set");
  a_reset_sets_bit: assert property (@(posedge clk) disable iff (!rst_b)
    event_core[DB_RESET] |=> target_doorbell[DB_RESET])
    else $error("reset doorbell not set");
  a_write_one_clears: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && db_clear[DB_RD_SENT] && !event_core[DB_RD_SENT]) |=> !target_doorbell[DB_RD_SENT])
    else $error("doorbell not cleared by write one");
  a_wr_ready_set: assert property (@(posedge clk) disable iff (!rst_b)
    event_core[DB_WR_READY] |=> target_doorbell[DB_WR_READY])
    else $error("write ready doorbell not set");
  a_packet_length: assert property (@(posedge clk) disable iff (!rst_b)
    packet_in |=> (host_length == $past(byte_count_core)) && target_doorbell[DB_PACKET])
    else $error("packet length not loaded");
  a_crc_aborts: assert property (@(posedge clk) disable iff (!rst_b)
    crc_abort |=> proc_doorbell[PD_ABORTED])
    else $error("crc error did not set aborted bit");
  a_irq_follows: assert property (@(posedge clk) disable iff (!rst_b)
    (target_doorbell != RESET_BYTE) == proc_irq)
    else $error("interrupt does not track doorbell");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (rd && mgmt_req.addr == 12'h000) |=> mgmt_rdata == RESET_BYTE)
    else $error("reserved read not zero");
  c_packet:   cover property (@(posedge clk) disable iff (!rst_b) packet_in);
  c_abort:    cover property (@(posedge clk) disable iff (!rst_b) event_core[DB_ABORT]);
  c_crc:      cover property (@(posedge clk) disable iff (!rst_b) crc_abort);
  c_regbus:   cover property (@(posedge clk) disable iff (!rst_b) rb_state == RB_DONE);

endmodule

//--- test/enclosure_proc_model.sv
// Enclosure processor model on the management slave port
`timescale 1ns/1ps
module enclosure_proc_model
  import mbox_pkg::*;
(
  input  wire logic       clk,
  output slave_req_t      mgmt_req,
  input  wire logic [7:0] mgmt_rdata
);
  // ************************************************************
  // Bus cycles
  // ************************************************************
  initial mgmt_req = '0;

  // One-cycle strobe, then a quiet cycle so back-to-back calls never merge
  task automatic put(input logic [11:0] a, input logic [7:0] d, input logic crc = 1'b0);
    @(posedge clk);
    mgmt_req <= '{1'b1, 1'b0, a, d, crc};
    @(posedge clk);
    mgmt_req <= '0;
    // Let the write settle so callers never sample in the launching time step
    #1;
  endtask

  task automatic get(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    mgmt_req <= '{1'b0, 1'b1, a, 8'h00, 1'b0};
    @(posedge clk);
    mgmt_req <= '0;
    @(posedge clk);
    #1 d = mgmt_rdata;
  endtask

  // ************************************************************
  // Reactions to target doorbells
  // ************************************************************
  task automatic serve(input logic pass, output logic [7:0] db);
    get(TARGET_DOORBELL, db);
    put(TARGET_DOORBELL, db);
    if (db[DB_DIAG] || db[DB_SOFT_RST]) put(CMD_STATUS, pass ? 8'h01 : 8'h00);
    if (db[DB_RESET]) put(PROC_DOORBELL, 8'h80);
    if (db[DB_IDENTIFY]) begin
      for (int i = 0; i < 512; i++) put(12'(RAM_FIRST + i), i[7:0]);
      put(PROC_DOORBELL, 8'h20);
    end
    if (db[DB_WR_READY]) put(PROC_DOORBELL, 8'h10);
  endtask

  task automatic packet(input logic dir_in, input logic [7:0] len);
    put(XFER_ATTR, {6'h00, 1'b1, dir_in});
    if (dir_in) put(PROC_DOORBELL, 8'h20);
    else begin
      put(P2H_LENGTH, len);
      put(PROC_DOORBELL, 8'h01);
    end
  endtask

  task automatic reject;
    put(CMD_STATUS, 8'h05);
    put(PROC_DOORBELL, 8'h40);
  endtask
endmodule

//--- test/tb_stp_enclosure_mailbox.sv
// Self-checking bench for the STP enclosure mailbox
`timescale 1ns/1ps
module tb_stp_enclosure_mailbox
  import mbox_pkg::*;
;
  logic          clk = 1'b0;
  logic          link_clk;
  logic          rst_b;
  logic          ce;
  slave_req_t    mgmt_req;
  logic [7:0]    mgmt_rdata;
  logic          proc_irq;
  target_event_t link_event;
  logic [7:0]    link_byte_count;
  ram_port_t     link_ram;
  logic [7:0]    link_ram_rdata;
  logic          proc_read_ready;
  logic          proc_packet_ack;
  logic          proc_write_ack;
  logic          proc_status_ready;
  logic          proc_aborted;
  logic [7:0]    proc_length;
  logic [7:0]    attributes;
  logic [7:0]    command_status;
  logic [31:0]   regbus_command;
  logic [63:0]   regbus_wdata;
  logic          regbus_req;
  logic          regbus_done;
  logic [63:0]   regbus_rdata;
  int            num_errors = 0;
  int            compares = 0;
  logic [7:0]    v;
  logic [7:0]    cnt;
  logic [7:0]    cdb;
  logic          pass;
  logic          dir;
  logic [31:0]   cmd;
  logic [63:0]   wdat;
  logic [63:0]   rdat;
  logic [11:0]   rsv [5] = '{12'h000, 12'h003, 12'h420, 12'h508, 12'h60D};

  always #10 clk = ~clk;
  // Link clock offset so its edges never line up with the core clock
  initial begin
    link_clk = 1'b0;
    #3;
    forever #24 link_clk = ~link_clk;
  end

  stp_enclosure_mailbox i_stp_enclosure_mailbox (
    .clk(clk), .rst_b(rst_b), .ce(ce), .link_clk(link_clk), .mgmt_req(mgmt_req),
    .mgmt_rdata(mgmt_rdata), .proc_irq(proc_irq), .link_event(link_event),
    .link_byte_count(link_byte_count), .link_ram(link_ram), .link_ram_rdata(link_ram_rdata),
    .proc_read_ready(proc_read_ready), .proc_packet_ack(proc_packet_ack),
    .proc_write_ack(proc_write_ack), .proc_status_ready(proc_status_ready),
    .proc_aborted(proc_aborted), .proc_length(proc_length), .attributes(attributes),
    .command_status(command_status), .regbus_command(regbus_command),
    .regbus_wdata(regbus_wdata), .regbus_req(regbus_req), .regbus_done(regbus_done),
    .regbus_rdata(regbus_rdata)
  );

  enclosure_proc_model i_enclosure_proc_model (
    .clk(clk), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Event struct is packed opposite to the doorbell byte
  function automatic int db_of(input int j);
    return 7 - j;
  endfunction

  task automatic fire(input int j);
    @(posedge link_clk);
    link_event <= target_event_t'(8'h01 << j);
    @(posedge link_clk);
    link_event <= '0;
    repeat (2) @(posedge link_clk);
  endtask

  task automatic close_out;
    $display("Compares %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #1_000_000;
    num_errors++;
    close_out();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    void'($urandom(32'h4B43C23A));
    ce = 1'b1;
    rst_b = 1'b0;
    link_event = '0;
    link_byte_count = 8'h00;
    link_ram = '0;
    regbus_done = 1'b0;
    regbus_rdata = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    i_enclosure_proc_model.get(TARGET_DOORBELL, v);
    check(v, 8'h00);
    check(proc_irq, 1'b0);
    i_enclosure_proc_model.get(ERR_DET_CTRL, v);
    check(v, EDC_RESET);
    foreach (rsv[k]) begin
      i_enclosure_proc_model.put(rsv[k], 8'hA5);
      i_enclosure_proc_model.get(rsv[k], v);
      check(v, 8'h00);
    end
    for (int j = 0; j < 8; j++) begin
      pass = 1'($urandom_range(0, 1));
      fire(j);
      check(proc_irq, 1'b1);
      i_enclosure_proc_model.serve(pass, v);
      check(v, 8'h01 << db_of(j));
      check(proc_irq, 1'b0);
      case (db_of(j))
        DB_DIAG:     check(command_status, {7'h00, pass});
        DB_SOFT_RST: check(command_status, {7'h00, pass});
        DB_RESET:    check(proc_aborted, 1'b1);
        DB_IDENTIFY: check(proc_read_ready, 1'b1);
        DB_WR_READY: check(proc_write_ack, 1'b1);
        default: ;
      endcase
    end
    @(posedge link_clk);
    link_ram <= '{10'h005, 8'h00, 1'b0};
    repeat (2) @(posedge link_clk);
    #1 check(link_ram_rdata, 8'h05);
    // Zero byte count first: it stands for the longest transfer
    for (int n = 0; n < 4; n++) begin
      cnt = (n == 0) ? 8'h00 : 8'($urandom_range(1, 255));
      cdb = 8'($urandom);
      dir = 1'($urandom_range(0, 1));
      @(posedge link_clk);
      link_ram <= '{10'h000, cdb, 1'b1};
      link_byte_count <= cnt;
      @(posedge link_clk);
      link_ram <= '0;
      fire(7);
      i_enclosure_proc_model.get(H2P_LENGTH, v);
      check(v, cnt);
      i_enclosure_proc_model.get(RAM_FIRST, v);
      check(v, cdb);
      i_enclosure_proc_model.put(PROC_DOORBELL, 8'h00);
      i_enclosure_proc_model.packet(dir, ~cnt);
      check(attributes & ATTR_MSK, {6'h00, 1'b1, dir});
      if (dir) check(proc_read_ready, 1'b1);
      else check({proc_length, proc_packet_ack}, {~cnt, 1'b1});
      i_enclosure_proc_model.put(TARGET_DOORBELL, 8'h01);
    end
    i_enclosure_proc_model.reject();
    check({command_status, proc_status_ready}, {8'h05, 1'b1});
    // Clock enable low must freeze the registers against a write
    ce <= 1'b0;
    i_enclosure_proc_model.put(CMD_STATUS, 8'h33);
    ce <= 1'b1;
    check(command_status, 8'h05);
    i_enclosure_proc_model.put(PROC_DOORBELL, 8'h00);
    i_enclosure_proc_model.put(ERR_DET_CTRL, 8'h00);
    i_enclosure_proc_model.put(P2H_LENGTH, 8'h3C, 1'b1);
    check(proc_aborted, 1'b0);
    i_enclosure_proc_model.put(ERR_DET_CTRL, EDC_RESET);
    i_enclosure_proc_model.put(P2H_LENGTH, 8'h3C, 1'b1);
    check(proc_aborted, 1'b1);
    cmd = $urandom;
    wdat = {$urandom, $urandom};
    rdat = {$urandom, $urandom};
    for (int k = 0; k < 4; k++) i_enclosure_proc_model.put(12'(REGBUS_CMD0 + k), cmd[8*k +: 8]);
    for (int k = 0; k < 8; k++) i_enclosure_proc_model.put(12'(REGBUS_DATA0 + k), wdat[8*k +: 8]);
    i_enclosure_proc_model.put(REGBUS_CTRL, 8'h01);
    for (int t = 0; t < 20 && regbus_req !== 1'b1; t++) @(posedge clk);
    check({regbus_req, regbus_command, regbus_wdata}, {1'b1, cmd, wdat});
    @(posedge clk);
    regbus_done <= 1'b1;
    regbus_rdata <= rdat;
    @(posedge clk);
    regbus_done <= 1'b0;
    @(posedge clk);
    #1 check(regbus_req, 1'b0);
    for (int k = 0; k < 8; k++) begin
      i_enclosure_proc_model.get(12'(REGBUS_DATA0 + k), v);
      check(v, rdat[8*k +: 8]);
    end
    i_enclosure_proc_model.put(REGBUS_CTRL, 8'h00);
    close_out();
  end
endmodule
